//--- rtl/ehp_pkg.sv
// Purpose: shared constants and types for the host slave port link
// Assumes: 200 MHz clk, all link pins sampled synchronously
// Notes:   window base and timing counts live here
package ehp_pkg;
  localparam int          EHP_CLK_PERIOD_PS = 5000;
  // io window compare, address bits 15 down to 4
  localparam int          EHP_WIN_HI        = 15;
  localparam int          EHP_WIN_LO        = 4;
  localparam logic [11:0] EHP_WIN_BASE      = 12'h030;
  // bus clock period of the host side, in ns
  localparam int          EHP_BCLK_NS       = 120;
  localparam int          EHP_HALF_BCLK_NS  = EHP_BCLK_NS / 2;
  // half a bus clock, rounded down; used as the shortest strobe width
  localparam int          EHP_HALF_BCLK_CYC =
    (EHP_HALF_BCLK_NS * 1000) / EHP_CLK_PERIOD_PS;
  localparam int          EHP_STRB_CYC      =
    (EHP_HALF_BCLK_CYC < 1) ? 1 : EHP_HALF_BCLK_CYC;
  // address setup before the strobe, in clk cycles
  localparam int          EHP_SETUP_CYC     = 2;
  localparam logic [15:0] EHP_DATA_RST      = 16'h0000;
  localparam logic [7:0]  EHP_CNT_W8        = 8'h00;

  typedef enum logic [1:0] {EHP_LANE_BOTH, EHP_LANE_LO, EHP_LANE_HI,
                            EHP_LANE_NONE} ehp_lane_t;

  // byte-lane enables (active low) to lane selection
  function automatic logic [1:0] ehp_lane_sel(input logic be0_n,
                                              input logic be1_n);
    ehp_lane_sel = {~be1_n, ~be0_n};
  endfunction
endpackage

//--- rtl/ehp_link_if.sv
// Purpose: pins between the slave port and the bus glue
// Assumes: one clock domain, data pins split by direction
// Notes:   data enable is active low, no shared data wire is modelled
`timescale 1ns/1ps
`default_nettype none
interface ehp_link_if;
  logic        addr_latch_strobe_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic        io_space_qualifier;
  logic        byte_lane0_enable_n;
  logic        byte_lane1_enable_n;
  logic [15:2] addr;
  logic        addr_bit1;
  logic        bus_mode_select_n;
  logic [15:0] data_h2d;
  logic [15:0] data_d2h;
  logic [1:0]  data_d2h_oe_n;
  logic        irq_out;
  logic        local_decode_hit_n;
  logic        async_ready;

  modport dev (
    input  addr_latch_strobe_n, read_strobe_n, write_strobe_n,
           io_space_qualifier, byte_lane0_enable_n, byte_lane1_enable_n,
           addr, addr_bit1, bus_mode_select_n, data_h2d,
    output data_d2h, data_d2h_oe_n, irq_out, local_decode_hit_n,
           async_ready
  );
  modport host (
    output addr_latch_strobe_n, read_strobe_n, write_strobe_n,
           io_space_qualifier, byte_lane0_enable_n, byte_lane1_enable_n,
           addr, addr_bit1, bus_mode_select_n, data_h2d,
    input  data_d2h, data_d2h_oe_n, irq_out, local_decode_hit_n,
           async_ready
  );
endinterface
`default_nettype wire

//--- rtl/ehp_dev_port.sv
// Purpose: device end of the 16-bit asynchronous io slave port
// Assumes: strobes sampled on clk; host glue keeps its own timing
// Notes:   core side sees one-cycle read/write pulses with lane mask
`timescale 1ns/1ps
`default_nettype none
module ehp_dev_port
  import ehp_pkg::*;
(
  input  wire logic        clk,          // device clock
  input  wire logic        sys_rst,      // async reset, active high
  ehp_link_if.dev          link,         // host bus pins
  input  wire logic [15:0] rd_data,      // core read data for address
  input  wire logic        core_busy,    // core cannot finish access now
  input  wire logic        core_event,   // core interrupt event level
  output logic             wr_pulse,     // one-cycle write to core
  output logic             rd_pulse,     // one-cycle read start to core
  output logic [15:2]      acc_addr,     // latched access address
  output logic [1:0]       acc_lanes,    // latched lane mask, bit0 low
  output logic [15:0]      wr_data       // captured write data
);

  // ------------------------------------------------------------
  // address phase latches
  // ------------------------------------------------------------
  logic [15:2] addr_r;
  logic        qual_r;
  logic [1:0]  be_n_r;
  logic        rd_d_r;
  logic        wr_d_r;
  logic [15:2] addr_eff;
  logic        qual_eff;
  logic        rd_fall;
  logic        wr_fall;
  logic        wr_rise;

  assign rd_fall  = ~link.read_strobe_n & rd_d_r;
  assign wr_fall  = ~link.write_strobe_n & wr_d_r;
  assign wr_rise  = link.write_strobe_n & ~wr_d_r;

  // transparent while the strobe is low, the latch holds afterwards
  assign addr_eff = link.addr_latch_strobe_n ? addr_r : link.addr;
  assign qual_eff = link.addr_latch_strobe_n ? qual_r
                                             : link.io_space_qualifier;

  // edge history of the incoming strobes; idle level after reset so
  // that the release of reset never looks like a strobe edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_d_r  <= 1'b1;
      wr_d_r  <= 1'b1;
    end else begin
      rd_d_r  <= link.read_strobe_n;
      wr_d_r  <= link.write_strobe_n;
    end
  end

  // address, qualifier and enables follow while low, freeze at the rise;
  // a level latch on clk needs no separate edge detector, at the cost
  // of following any glitch on the pins while the strobe is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r <= 14'h0000;
      qual_r <= 1'b1;
      be_n_r <= 2'h3;
    end else if (!link.addr_latch_strobe_n) begin
      addr_r <= link.addr;
      qual_r <= link.io_space_qualifier;
      be_n_r <= {link.byte_lane1_enable_n,
                 link.byte_lane0_enable_n};
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic hit;
  logic hit_n_r;
  logic [1:0] lanes;

  assign hit = (addr_eff[EHP_WIN_HI:EHP_WIN_LO] == EHP_WIN_BASE) & ~qual_eff;
  assign lanes = ehp_lane_sel(be_n_r[0], be_n_r[1]);

  // registered decode hit keeps the pin glitch free
  // the hit stays up while idle, as window and qualifier are latched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_n_r <= 1'b1;
    end else begin
      hit_n_r <= ~hit;
    end
  end
  assign link.local_decode_hit_n = hit_n_r;

  // ------------------------------------------------------------
  // data phase
  // ------------------------------------------------------------
  logic [15:0] dout_r;
  logic [1:0]  oe_n_r;
  logic [15:0] wdat_r;
  logic        wr_pulse_r;
  logic        rd_pulse_r;
  logic [15:2] acc_addr_r;
  logic [1:0]  acc_lanes_r;
  logic        rd_act;

  assign rd_act = ~link.read_strobe_n & hit;

  // read drive: only selected lanes leave tri-state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dout_r <= EHP_DATA_RST;
      oe_n_r <= 2'h3;
    end else begin
      dout_r <= rd_data;
      oe_n_r <= rd_act ? ~lanes : 2'h3;
    end
  end
  assign link.data_d2h      = dout_r;
  assign link.data_d2h_oe_n = oe_n_r;

  // write data sampled while the strobe is low, used at its rise
  // the last low sample is the value present at the trailing edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdat_r <= EHP_DATA_RST;
    end else if (!link.write_strobe_n) begin
      wdat_r <= link.data_h2d;
    end
  end

  // core pulses; ignored lanes keep old data so writes stay masked
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pulse_r  <= 1'b0;
      rd_pulse_r  <= 1'b0;
      acc_addr_r  <= 14'h0000;
      acc_lanes_r <= 2'h0;
      wr_data     <= EHP_DATA_RST;
    end else begin
      wr_pulse_r <= wr_rise & hit;
      rd_pulse_r <= rd_fall & hit;
      if ((wr_rise | rd_fall) & hit) begin
        acc_addr_r  <= addr_eff;
        acc_lanes_r <= lanes;
      end
      if (wr_rise & hit) begin
        if (lanes[0]) wr_data[7:0]  <= wdat_r[7:0];
        if (lanes[1]) wr_data[15:8] <= wdat_r[15:8];
      end
    end
  end
  assign wr_pulse  = wr_pulse_r;
  assign rd_pulse  = rd_pulse_r;
  assign acc_addr  = acc_addr_r;
  assign acc_lanes = acc_lanes_r;

  // ------------------------------------------------------------
  // ready and interrupt
  // ------------------------------------------------------------
  logic rdy_r;
  logic irq_r;

  // no wait states are normally needed; busy core is the rare case.
  // ready drops one clk after the strobe falls, which the host glue
  // covers by looking at it only after its fixed strobe width
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_r <= 1'b1;
    end else if ((rd_fall | wr_fall) & hit & core_busy) begin
      rdy_r <= 1'b0;
    end else if (!core_busy) begin
      rdy_r <= 1'b1;
    end
  end
  assign link.async_ready = rdy_r;

  // level follows the event; the host sees its rising edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= core_event;
    end
  end
  assign link.irq_out = irq_r;

endmodule
`default_nettype wire

//--- rtl/ehp_host_glue.sv
// Purpose: host end: bus glue that drives the slave port pins
// Assumes: user issues one access at a time when idle
// Notes:   strobes are timed off clk; compressed mode shortens them
`timescale 1ns/1ps
`default_nettype none
module ehp_host_glue
  import ehp_pkg::*;
(
  input  wire logic        clk,          // system clock
  input  wire logic        sys_rst,      // async reset, active high
  ehp_link_if.host         link,         // port pins
  input  wire logic        req,          // access request pulse
  input  wire logic        req_write,    // 1 write, 0 read
  input  wire logic        mem_io_sel,   // memory/io select, low io
  input  wire logic        addr_enable,  // bus address enable
  input  wire logic        compressed,   // request short strobes
  input  wire logic [15:2] req_addr,     // access address
  input  wire logic [1:0]  req_be_n,     // byte enables, active low
  input  wire logic [15:0] req_wdata,    // write data
  output logic             busy,         // access in progress
  output logic             done,         // one-cycle completion
  output logic [15:0]      rdata,        // captured read data
  output logic             irq_edge,     // one-cycle irq rise seen
  output logic             no_wait_n     // no-wait-state request
);
  typedef enum logic [2:0] {EHP_IDLE, EHP_START, EHP_SETUP, EHP_STRB,
                            EHP_WAIT, EHP_END} ehp_state_t;
  ehp_state_t  st_r;
  logic [7:0]  cnt_r;
  logic        wr_r;
  logic        irq_d_r;
  logic [7:0]  strb_len;

  assign strb_len = compressed ? 8'(EHP_STRB_CYC) : 8'(2 * EHP_STRB_CYC);

  // access sequencer: start strobe, setup, command, optional wait
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r                     <= EHP_IDLE;
      cnt_r                    <= EHP_CNT_W8;
      wr_r                     <= 1'b0;
      link.addr_latch_strobe_n <= 1'b1;
      link.read_strobe_n       <= 1'b1;
      link.write_strobe_n      <= 1'b1;
      link.addr                <= 14'h0000;
      link.byte_lane0_enable_n <= 1'b1;
      link.byte_lane1_enable_n <= 1'b1;
      link.data_h2d            <= EHP_DATA_RST;
      done                     <= 1'b0;
      rdata                    <= EHP_DATA_RST;
    end else begin
      done <= 1'b0;
      case (st_r)
        EHP_IDLE: begin
          if (req) begin
            wr_r                     <= req_write;
            link.addr                <= req_addr;
            link.byte_lane0_enable_n <= req_be_n[0];
            link.byte_lane1_enable_n <= req_be_n[1];
            link.data_h2d            <= req_wdata;
            link.addr_latch_strobe_n <= 1'b0;
            st_r                     <= EHP_START;
          end
        end
        EHP_START: begin
          link.addr_latch_strobe_n <= 1'b1;
          cnt_r <= 8'(EHP_SETUP_CYC);
          st_r  <= EHP_SETUP;
        end
        EHP_SETUP: begin
          if (cnt_r <= 8'h01) begin
            link.read_strobe_n  <= wr_r;
            link.write_strobe_n <= ~wr_r;
            cnt_r <= strb_len;
            st_r  <= EHP_STRB;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        EHP_STRB: begin
          if (cnt_r <= 8'h01) begin
            st_r <= EHP_WAIT;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        EHP_WAIT: begin
          if (link.async_ready) begin
            if (!wr_r) rdata <= link.data_d2h;
            link.read_strobe_n  <= 1'b1;
            link.write_strobe_n <= 1'b1;
            st_r <= EHP_END;
          end
        end
        EHP_END: begin
          done <= 1'b1;
          st_r <= EHP_IDLE;
        end
        default: st_r <= EHP_IDLE;
      endcase
    end
  end
  assign busy = (st_r != EHP_IDLE);

  // merged qualifier and tied pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.io_space_qualifier <= 1'b1;
      link.bus_mode_select_n  <= 1'b1;
      link.addr_bit1          <= 1'b0;
    end else begin
      link.io_space_qualifier <= mem_io_sel | addr_enable;
      link.bus_mode_select_n  <= 1'b1;
      link.addr_bit1          <= 1'b0;
    end
  end

  // no-wait follows decode hit in compressed mode only, released at start strobe rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      no_wait_n <= 1'b1;
    end else if (st_r == EHP_START) begin
      no_wait_n <= 1'b1;
    end else begin
      no_wait_n <= link.local_decode_hit_n | ~compressed;
    end
  end

  // interrupt seen as rising edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_d_r  <= 1'b0;
      irq_edge <= 1'b0;
    end else begin
      irq_d_r  <= link.irq_out;
      irq_edge <= link.irq_out & ~irq_d_r;
    end
  end
endmodule
`default_nettype wire

//--- sim/ehp_link_assertions.sv
// Purpose: concurrent checks on the slave port link pins
// Assumes: one clock domain, async active-high reset
// Notes:   watches only link signals; sits beside the link instance
`timescale 1ns/1ps
`default_nettype none
module ehp_link_assertions
  import ehp_pkg::*;
(
  input wire logic        clk,                 // device clock
  input wire logic        sys_rst,             // async reset
  input wire logic        addr_latch_strobe_n, // address latch
  input wire logic        read_strobe_n,       // read strobe
  input wire logic        write_strobe_n,      // write strobe
  input wire logic        io_space_qualifier,  // low allows decode
  input wire logic [15:2] addr,                // access address
  input wire logic        addr_bit1,           // tied pin
  input wire logic        bus_mode_select_n,   // tied pin
  input wire logic [1:0]  data_d2h_oe_n,       // lane drive, low on
  input wire logic        local_decode_hit_n,  // decode hit
  input wire logic        async_ready          // ready to host
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // strobe length counter
  // ---------------------------------------------------------------
  // saturates so a stuck strobe cannot wrap into a legal width
  logic [7:0] lo_cnt_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_cnt_r <= 8'h00;
    end else if (read_strobe_n && write_strobe_n) begin
      lo_cnt_r <= 8'h00;
    end else if (lo_cnt_r != 8'hFF) begin
      lo_cnt_r <= lo_cnt_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  win_hit_a: assert property (
    ($fell(read_strobe_n) || $fell(write_strobe_n)) |->
    local_decode_hit_n ==
      !((addr[15:4] == EHP_WIN_BASE) && !io_space_qualifier))
    else $error("decode hit wrong at strobe start");
  tie_pins_a: assert property (bus_mode_select_n && !addr_bit1)
    else $error("tied pins not at level");
  strobe_excl_a: assert property (read_strobe_n || write_strobe_n)
    else $error("read and write strobes both low");
  addr_setup_a: assert property (
    ($fell(read_strobe_n) || $fell(write_strobe_n)) |->
    addr_latch_strobe_n && $stable(addr))
    else $error("address not settled at strobe start");
  strobe_width_a: assert property (
    $rose(read_strobe_n && write_strobe_n) |-> lo_cnt_r >= EHP_STRB_CYC)
    else $error("strobe shorter than half bus clock");
  lane_drive_a: assert property (
    data_d2h_oe_n != 2'b11 |->
    !$past(read_strobe_n) || !$past(read_strobe_n, 2))
    else $error("data driven outside a read");
  ready_drop_a: assert property (
    $fell(async_ready) |-> !read_strobe_n || !write_strobe_n)
    else $error("ready dropped outside a strobe");
  ready_idle_a: assert property (
    (read_strobe_n && write_strobe_n)[*2] |-> async_ready)
    else $error("ready low while idle");
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose: self-checking bench, host glue facing the slave port
// Assumes: 200 MHz clk, inputs driven 1 ns after the rising edge
// Notes:   per-access monitors are cleared by the access task
`timescale 1ns/1ps
`default_nettype none
module tb
  import ehp_pkg::*;
;
  localparam logic [15:2] HIT = {EHP_WIN_BASE, 2'h1};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req = 1'b0, req_write = 1'b0, mem_io_sel = 1'b0;
  logic        addr_enable = 1'b0, compressed = 1'b0;
  logic        core_busy = 1'b0, core_event = 1'b0;
  logic [15:2] req_addr = '0;
  logic [1:0]  req_be_n = 2'b00;
  logic [15:0] req_wdata = 16'h0000, rd_data = 16'hA5C3;
  logic        busy, done, irq_edge, no_wait_n, wr_pulse, rd_pulse;
  logic [15:0] rdata, wr_data, exp_w, m;
  logic [15:2] acc_addr;
  logic [1:0]  acc_lanes, be;
  logic [15:0] n_wr, n_rd, n_irq, slen, smax, oe_all, hit_lo, rdy_lo;
  logic [15:0] nw_lo;
  int          errors = 0, checked = 0, cyc = 0, i;

  ehp_link_if link ();
  ehp_dev_port ehp_dev_port_inst (.clk(clk), .sys_rst(sys_rst),
    .link(link), .rd_data(rd_data), .core_busy(core_busy),
    .core_event(core_event), .wr_pulse(wr_pulse), .rd_pulse(rd_pulse),
    .acc_addr(acc_addr), .acc_lanes(acc_lanes), .wr_data(wr_data));
  ehp_host_glue ehp_host_glue_inst (.clk(clk), .sys_rst(sys_rst),
    .link(link), .req(req), .req_write(req_write),
    .mem_io_sel(mem_io_sel), .addr_enable(addr_enable),
    .compressed(compressed), .req_addr(req_addr), .req_be_n(req_be_n),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata),
    .irq_edge(irq_edge), .no_wait_n(no_wait_n));
  ehp_link_assertions ehp_link_assertions_inst (.clk(clk),
    .sys_rst(sys_rst), .addr_latch_strobe_n(link.addr_latch_strobe_n),
    .read_strobe_n(link.read_strobe_n),
    .write_strobe_n(link.write_strobe_n),
    .io_space_qualifier(link.io_space_qualifier), .addr(link.addr),
    .addr_bit1(link.addr_bit1),
    .bus_mode_select_n(link.bus_mode_select_n),
    .data_d2h_oe_n(link.data_d2h_oe_n),
    .local_decode_hit_n(link.local_decode_hit_n),
    .async_ready(link.async_ready));

  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // monitors, sampled on the edge so design updates are not seen
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
    if (wr_pulse === 1'b1) n_wr++;
    if (rd_pulse === 1'b1) n_rd++;
    if (irq_edge === 1'b1) n_irq++;
    oe_all[1:0] = oe_all[1:0] & link.data_d2h_oe_n;
    // decode counted inside a strobe only: the latched window keeps it
    // up while idle after an earlier hit
    if (link.local_decode_hit_n === 1'b0 &&
        !(link.read_strobe_n && link.write_strobe_n)) hit_lo = 16'h0001;
    if (link.async_ready === 1'b0) rdy_lo = 16'h0001;
    if (no_wait_n === 1'b0) nw_lo = 16'h0001;
    if (!(link.read_strobe_n && link.write_strobe_n)) begin
      slen++;
    end else begin
      if (slen > smax) smax = slen;
      slen = 16'h0000;
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one host access through the glue, waits for its completion
  task automatic access(input logic wr, input logic [15:2] a,
                        input logic [1:0] b, input logic [15:0] wd,
                        input logic cmp, input logic q);
    int k;
    @(posedge clk);
    #1;
    req = 1'b1; req_write = wr; req_addr = a; req_be_n = b;
    req_wdata = wd; compressed = cmp; mem_io_sel = q;
    n_wr = 0; n_rd = 0; smax = 0; slen = 0; oe_all = 16'h0003;
    hit_lo = 0; rdy_lo = 0; nw_lo = 0;
    @(posedge clk);
    #1 req = 1'b0;
    check("busy", {15'h0, busy}, 16'h0001);
    for (k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("done", {15'h0, done}, 16'h0001);
    // the write pulse rises with done and the monitor counts it one edge later, so let it land
    @(posedge clk);
    #1;
    check("idle", {15'h0, busy}, 16'h0000);
  endtask

  task automatic stop_test();
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("rst", {11'h0, link.irq_out, link.local_decode_hit_n,
      link.async_ready, link.data_d2h_oe_n}, 16'h000F);
    exp_w = 16'h0000;
    // lane codes 00, 10 and 01 (not 11), normal then compressed strobes
    for (i = 0; i < 6; i++) begin
      be = (i % 3 == 0) ? 2'b00 : ((i % 3 == 1) ? 2'b10 : 2'b01);
      m = {{8{!be[1]}}, {8{!be[0]}}};
      access(1'b1, HIT, be, 16'h1E2D ^ 16'(i * 16'h1111), i >= 3, 1'b0);
      exp_w = (exp_w & ~m) | ((16'h1E2D ^ 16'(i * 16'h1111)) & m);
      check("wr_cnt", n_wr, 16'h0001);
      check("wr_data", wr_data, exp_w);
      check("lanes", {14'h0, acc_lanes}, {14'h0, ~be});
      check("addr", {acc_addr, 2'h0}, {HIT, 2'h0});
      check("hit", hit_lo, 16'h0001);
      check("nowait", nw_lo, {15'h0, i >= 3});
      check("width", {15'h0, (i >= 3) ? (smax < 2 * EHP_STRB_CYC)
        : (smax >= 2 * EHP_STRB_CYC)}, 16'h0001);
      access(1'b0, HIT, be, 16'h0000, i >= 3, 1'b0);
      check("rd_cnt", n_rd, 16'h0001);
      check("rdata", rdata & m, 16'hA5C3 & m);
      check("oe", oe_all, {14'h0, be});
    end
    // refused: outside window, memory cycle, address enable
    for (i = 0; i < 3; i++) begin
      addr_enable = (i == 2);
      access(1'b1, (i == 0) ? ~HIT : HIT, 2'b00, 16'hFFFF, 1'b0, i == 1);
      access(1'b0, (i == 0) ? ~HIT : HIT, 2'b00, 16'h0000, 1'b0, i == 1);
      check("miss_acc", n_wr + n_rd, 16'h0000);
      check("miss_hit", hit_lo, 16'h0000);
      check("miss_oe", oe_all, 16'h0003);
      check("miss_data", wr_data, exp_w);
    end
    addr_enable = 1'b0;
    // slow core stretches the read through the ready line
    core_busy = 1'b1;
    fork
      access(1'b0, HIT, 2'b00, 16'h0000, 1'b0, 1'b0);
      begin
        repeat (60) @(posedge clk);
        #1 core_busy = 1'b0;
      end
    join
    check("rdy_lo", rdy_lo, 16'h0001);
    check("stretch", {15'h0, smax > 2 * EHP_STRB_CYC}, 16'h0001);
    check("slow_rd", rdata, 16'hA5C3);
    // interrupt edge toward the host
    core_event = 1'b1;
    n_irq = 0;
    repeat (10) @(posedge clk);
    check("irq_edge", n_irq, 16'h0001);
    check("irq_hi", {15'h0, link.irq_out}, 16'h0001);
    #1 core_event = 1'b0;
    repeat (10) @(posedge clk);
    check("irq_lo", {15'h0, link.irq_out}, 16'h0000);
    check("irq_fall", n_irq, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire
